/* File: logic/dpt_pkg.sv */
// Operation
// RULE1: Mode bit selects timer or event counting
// RULE2: Noise rejector on event input when selected
// RULE3: Polarity bit picks counted input edge
// RULE4: Channel bit picks timer driving square output
// RULE5: Output control bit enables square output pin
// RULE6: Source bit picks fast or slow oscillator
// RULE7: Prescaler codes divide by 1, 4, 32, 256
// RULE8: Writing 1 to reset bit reloads counter
// RULE9: Run bit starts and halts counting
// RULE10: Eight-bit reload value in two nibbles
// RULE11: Timer 0 count readable as two nibbles
// RULE12: Mode register bit 3 reads zero
// RULE13: Timer 1 count readable as two nibbles
// RULE14: Interrupt mask bit per timer enables it
// RULE15: Factor flag set on underflow, write-1 clears
// RULE16: Decrement per tick, reload, flag, toggle
package dpt_pkg;

   localparam logic [15:0] DPT_ADDR_MODE  = 16'hffc0;
   localparam logic [15:0] DPT_ADDR_OUTCK = 16'hffc1;
   localparam logic [15:0] DPT_ADDR_PSR0  = 16'hffc2;
   localparam logic [15:0] DPT_ADDR_PSR1  = 16'hffc3;
   localparam logic [15:0] DPT_ADDR_RLD0L = 16'hffc4;
   localparam logic [15:0] DPT_ADDR_RLD0H = 16'hffc5;
   localparam logic [15:0] DPT_ADDR_RLD1L = 16'hffc6;
   localparam logic [15:0] DPT_ADDR_RLD1H = 16'hffc7;
   localparam logic [15:0] DPT_ADDR_CNT0L = 16'hffc8;
   localparam logic [15:0] DPT_ADDR_CNT0H = 16'hffc9;
   localparam logic [15:0] DPT_ADDR_CNT1L = 16'hffca;
   localparam logic [15:0] DPT_ADDR_CNT1H = 16'hffcb;
   localparam logic [15:0] DPT_ADDR_MASK  = 16'hffe2;
   localparam logic [15:0] DPT_ADDR_FLAG  = 16'hfff2;

   // Field positions
   localparam int DPT_MODE_POL   = 0;
   localparam int DPT_MODE_NR    = 1;
   localparam int DPT_MODE_EVT   = 2;
   localparam int DPT_OC_CK0     = 0;
   localparam int DPT_OC_CK1     = 1;
   localparam int DPT_OC_OUTEN   = 2;
   localparam int DPT_OC_OUTPUT_CHANNEL_SELECT   = 3;
   localparam int DPT_PS_RUN     = 0;
   localparam int DPT_PS_RST     = 1;
   localparam int DPT_PS_RATIO   = 2;

   localparam logic [3:0] DPT_NIB_RESET = 4'h0;
   localparam logic [7:0] DPT_BYTE_RESET = 8'h00;
   // Noise rejector: input must hold this many core cycles
   localparam logic [3:0] DPT_NR_CYCLES = 4'h4;

   typedef struct packed {
      logic       run;
      logic [1:0] ratio;
      logic       fast_src;
      logic [7:0] reload;
   } dpt_timer_cfg_t;

endpackage : dpt_pkg

/* File: logic/dpt_timer.sv */
`timescale 1ns/100ps
`default_nettype none

module dpt_timer
   import dpt_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       bus_wr_i,
   input  wire logic       bus_rd_i,
   input  wire logic [15:0] bus_addr_i,
   input  wire logic [3:0] bus_wdata_i,
   output logic      [3:0] bus_rdata_o,
   input  wire logic       slow_oscillator_i,
   input  wire logic       fast_oscillator_i,
   input  wire logic       event_in_i,
   output logic            timer_square_out_pin_o,
   output logic            timer0_irq_o,
   output logic            timer1_irq_o
);

   // Counter, reload and read-back paths are all built for one byte
   if (W != 8) begin : g_bad_width
      $error("dpt_timer supports only W = 8");
   end

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic [2:0] prev_q;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         prev_q  <= 3'h0;
      end else begin
         sync1_q <= {event_in_i, fast_oscillator_i, slow_oscillator_i};
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   logic slow_rise;
   logic fast_rise;
   assign slow_rise = sync2_q[0] & ~prev_q[0];
   assign fast_rise = sync2_q[1] & ~prev_q[1];

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   logic [2:0]     mode_q;
   logic [3:0]     outck_q;
   dpt_timer_cfg_t cfg_q [2];
   logic [1:0]     mask_q;
   logic [1:0]     flag_q;
   logic [1:0]     reload_req;
   logic [1:0]     uflow;
   logic [7:0]     cnt_q [2];

   function automatic logic hit(input logic [15:0] a,
                                input logic [15:0] b);
      return a == b;
   endfunction

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_q  <= 3'h0;                                   // RULE1
         outck_q <= DPT_NIB_RESET;
         mask_q  <= 2'h0;
      end else if (bus_wr_i) begin
         if (hit(bus_addr_i, DPT_ADDR_MODE))
            mode_q <= bus_wdata_i[2:0];                     // RULE1
         if (hit(bus_addr_i, DPT_ADDR_OUTCK))
            outck_q <= bus_wdata_i;                         // RULE4
         if (hit(bus_addr_i, DPT_ADDR_MASK))
            mask_q <= bus_wdata_i[1:0];                     // RULE14
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_cfg
         localparam logic [15:0] PSR = g ? DPT_ADDR_PSR1 : DPT_ADDR_PSR0;
         localparam logic [15:0] RL  = g ? DPT_ADDR_RLD1L : DPT_ADDR_RLD0L;
         localparam logic [15:0] RH  = g ? DPT_ADDR_RLD1H : DPT_ADDR_RLD0H;
         always_ff @(posedge core_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               cfg_q[g].run    <= 1'b0;
               cfg_q[g].ratio  <= 2'h0;
               cfg_q[g].reload <= DPT_BYTE_RESET;           // RULE10
               cfg_q[g].fast_src <= 1'b0;                   // RULE6
            end else if (bus_wr_i) begin
               if (hit(bus_addr_i, PSR)) begin
                  cfg_q[g].run   <= bus_wdata_i[DPT_PS_RUN]; // RULE9
                  cfg_q[g].ratio <= bus_wdata_i[3:2];        // RULE7
               end
               if (hit(bus_addr_i, RL))
                  cfg_q[g].reload[3:0] <= bus_wdata_i;      // RULE10
               if (hit(bus_addr_i, RH))
                  cfg_q[g].reload[7:4] <= bus_wdata_i;      // RULE10
               // Mirrors the source bit of the shared select register
               if (hit(bus_addr_i, DPT_ADDR_OUTCK))
                  cfg_q[g].fast_src <= bus_wdata_i[g];      // RULE6
            end
         end
         assign reload_req[g] = bus_wr_i & hit(bus_addr_i, PSR)
                                & bus_wdata_i[DPT_PS_RST];  // RULE8
      end
   endgenerate

   // ---------------------------------------------------------------
   // Event input with optional noise rejection
   // ---------------------------------------------------------------
   logic [3:0] nr_cnt_q;
   logic       nr_lvl_q;
   logic       evt_prev_q;
   logic       evt_lvl;
   logic       evt_tick;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         nr_cnt_q <= 4'h0;
         nr_lvl_q <= 1'b0;
      end else if (sync2_q[2] == nr_lvl_q) begin
         nr_cnt_q <= 4'h0;
      end else if (nr_cnt_q == DPT_NR_CYCLES - 4'h1) begin
         nr_cnt_q <= 4'h0;
         nr_lvl_q <= sync2_q[2];                            // RULE2
      end else begin
         nr_cnt_q <= nr_cnt_q + 4'h1;
      end
   end

   assign evt_lvl = mode_q[DPT_MODE_NR] ? nr_lvl_q : sync2_q[2]; // RULE2

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) evt_prev_q <= 1'b0;
      else          evt_prev_q <= evt_lvl;
   end

   // Polarity 0 counts falling edges, 1 rising edges
   assign evt_tick = mode_q[DPT_MODE_POL] ? (evt_lvl & ~evt_prev_q)
                                          : (~evt_lvl & evt_prev_q); // RULE3

   // ---------------------------------------------------------------
   // Prescalers and counters
   // ---------------------------------------------------------------
   logic [1:0] tick;
   logic [1:0] timer_square_out_pin_q;

   function automatic logic ps_tap(input logic [1:0] r,
                                   input logic [7:0] p);
      case (r)
         2'h0:    return 1'b1;
         2'h1:    return p[1:0] == 2'h3;
         2'h2:    return p[4:0] == 5'h1f;
         default: return p == 8'hff;
      endcase
   endfunction

   generate
      for (g = 0; g < 2; g++) begin : g_tmr
         logic [7:0] ps_q;
         logic       src;
         logic       ps_tick;
         assign src = cfg_q[g].fast_src ? fast_rise : slow_rise; // RULE6
         assign ps_tick = src & ps_tap(cfg_q[g].ratio, ps_q);    // RULE7
         always_ff @(posedge core_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) ps_q <= 8'h00;
            else if (!cfg_q[g].run) ps_q <= 8'h00;
            else if (src) ps_q <= ps_q + 8'h01;
         end
         if (g == 0) begin : g_ev
            assign tick[g] = mode_q[DPT_MODE_EVT] ? evt_tick
                                                   : ps_tick;    // RULE1
         end else begin : g_nev
            assign tick[g] = ps_tick;
         end
         assign uflow[g] = cfg_q[g].run & tick[g] & (cnt_q[g] == 8'h00);
         always_ff @(posedge core_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               cnt_q[g]  <= DPT_BYTE_RESET;                      // RULE11
               timer_square_out_pin_q[g] <= 1'b0;
            end else if (reload_req[g]) begin
               cnt_q[g] <= cfg_q[g].reload;                      // RULE8
            end else if (cfg_q[g].run && tick[g]) begin         // RULE9
               if (uflow[g]) begin
                  cnt_q[g]  <= cfg_q[g].reload;                  // RULE16
                  timer_square_out_pin_q[g] <= ~timer_square_out_pin_q[g];                       // RULE16
               end else begin
                  cnt_q[g] <= cnt_q[g] - 8'h01;                  // RULE16
               end
            end
         end
         // Set beats a write-1 clear in the same cycle
         always_ff @(posedge core_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) flag_q[g] <= 1'b0;
            else if (uflow[g]) flag_q[g] <= 1'b1;                // RULE15
            else if (bus_wr_i && hit(bus_addr_i, DPT_ADDR_FLAG)
                     && bus_wdata_i[g]) flag_q[g] <= 1'b0;       // RULE15
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   logic sq_sel;
   assign sq_sel = outck_q[DPT_OC_OUTPUT_CHANNEL_SELECT] ? timer_square_out_pin_q[1] : timer_square_out_pin_q[0]; // RULE4

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_square_out_pin_o <= 1'b0;
         timer0_irq_o <= 1'b0;
         timer1_irq_o <= 1'b0;
      end else begin
         timer_square_out_pin_o <= outck_q[DPT_OC_OUTEN] & sq_sel; // RULE5
         timer0_irq_o <= flag_q[0] & mask_q[0];                  // RULE14
         timer1_irq_o <= flag_q[1] & mask_q[1];                  // RULE14
      end
   end

   logic [3:0] rd_d;
   always_comb begin
      case (bus_addr_i)
         DPT_ADDR_MODE:  rd_d = {1'b0, mode_q};                  // RULE12
         DPT_ADDR_OUTCK: rd_d = outck_q;
         DPT_ADDR_PSR0:  rd_d = {cfg_q[0].ratio, 1'b0, cfg_q[0].run};
         DPT_ADDR_PSR1:  rd_d = {cfg_q[1].ratio, 1'b0, cfg_q[1].run};
         DPT_ADDR_RLD0L: rd_d = cfg_q[0].reload[3:0];
         DPT_ADDR_RLD0H: rd_d = cfg_q[0].reload[7:4];
         DPT_ADDR_RLD1L: rd_d = cfg_q[1].reload[3:0];
         DPT_ADDR_RLD1H: rd_d = cfg_q[1].reload[7:4];
         DPT_ADDR_CNT0L: rd_d = cnt_q[0][3:0];                   // RULE11
         DPT_ADDR_CNT0H: rd_d = cnt_q[0][7:4];                   // RULE11
         DPT_ADDR_CNT1L: rd_d = cnt_q[1][3:0];                   // RULE13
         DPT_ADDR_CNT1H: rd_d = cnt_q[1][7:4];                   // RULE13
         DPT_ADDR_MASK:  rd_d = {2'h0, mask_q};
         DPT_ADDR_FLAG:  rd_d = {2'h0, flag_q};
         default:        rd_d = 4'h0;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)      bus_rdata_o <= 4'h0;
      else if (bus_rd_i) bus_rdata_o <= rd_d;
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   mode_bit3_zero_a: assert property (                        // RULE12
      bus_rd_i && bus_addr_i == DPT_ADDR_MODE |=> bus_rdata_o[3] == 1'b0)
      else $error("mode bit 3 read nonzero");
   reload_trig_a: assert property (                           // RULE8
      reload_req[0] |=> cnt_q[0] == $past(cfg_q[0].reload))
      else $error("reload trigger did not load count");
   halt_hold_a: assert property (                             // RULE9
      !cfg_q[1].run && !reload_req[1] |=> $stable(cnt_q[1]))
      else $error("halted timer changed");
   flag_set_a: assert property (                              // RULE15
      uflow[0] |=> flag_q[0])
      else $error("underflow did not set flag");
   irq_mask_a: assert property (                              // RULE14
      flag_q[1] && !mask_q[1] |=> !timer1_irq_o)
      else $error("masked interrupt asserted");
   uflow_reload_a: assert property (                          // RULE16
      uflow[1] && !reload_req[1] |=> cnt_q[1] == $past(cfg_q[1].reload))
      else $error("underflow did not reload");
   dec_step_a: assert property (                              // RULE16
      cfg_q[0].run && tick[0] && !uflow[0] && !reload_req[0]
      |=> cnt_q[0] == $past(cnt_q[0]) - 8'h01)
      else $error("count did not decrement");
   out_off_a: assert property (                               // RULE5
      !outck_q[DPT_OC_OUTEN] |=> !timer_square_out_pin_o)
      else $error("square out active while disabled");
   evt_src_a: assert property (                               // RULE1
      mode_q[DPT_MODE_EVT] && !mode_q[DPT_MODE_POL]
      && !mode_q[DPT_MODE_NR] && $stable(mode_q)
      && $fell(sync2_q[2]) |-> tick[0])
      else $error("event mode not counting input edges");
   div1_a: assert property (                                  // RULE7
      cfg_q[1].run && cfg_q[1].ratio == 2'h0 |-> tick[1] == g_tmr[1].src)
      else $error("divide by one broken");

   underflow_c: cover property (uflow[0]);
   event_tick_c: cover property (mode_q[DPT_MODE_EVT] && evt_tick);
   clear_race_c: cover property (uflow[1] && bus_wr_i
                                 && bus_addr_i == DPT_ADDR_FLAG);

endmodule : dpt_timer

`default_nettype wire

/* File: testbench/dual_programmable_timer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; \
   if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module dual_programmable_timer_tb;
   import dpt_pkg::*;

   logic        clk   = 1'b0;
   logic        rst_n = 1'b0;
   logic        wr    = 1'b0;
   logic        rd    = 1'b0;
   logic [15:0] addr  = 16'h0000;
   logic [3:0]  wd    = 4'h0;
   logic        slow  = 1'b0;
   logic        fast  = 1'b0;
   logic        evt   = 1'b0;
   wire logic [3:0] rdat;
   wire logic   sq;
   wire logic   irq0;
   wire logic   irq1;
   int          fail_count = 0;
   int          checks = 0;
   int          k;
   logic [31:0] seed = 32'h01c581e8;
   logic [7:0]  r0;
   logic [7:0]  r1;

   dpt_timer dut (
      .core_clk_i             (clk),
      .rst_n_i                (rst_n),
      .bus_wr_i               (wr),
      .bus_rd_i               (rd),
      .bus_addr_i             (addr),
      .bus_wdata_i            (wd),
      .bus_rdata_o            (rdat),
      .slow_oscillator_i      (slow),
      .fast_oscillator_i      (fast),
      .event_in_i             (evt),
      .timer_square_out_pin_o (sq),
      .timer0_irq_o           (irq0),
      .timer1_irq_o           (irq1)
   );

   initial begin
      forever #4 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   function automatic int dv(input int c);
      return (c == 0) ? 1 : (c == 1) ? 4 : (c == 2) ? 32 : 256;
   endfunction

   task automatic wr_n(input logic [15:0] a, input logic [3:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_n(input logic [15:0] a, output logic [3:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      #1 v = rdat;
   endtask

   task automatic rchk(input logic [15:0] a, input logic [3:0] e,
                       input string n);
      logic [3:0] v;
      rd_n(a, v);
      `CHK(n, e, v)
   endtask

   task automatic ld(input int t, input logic [7:0] v);
      wr_n(DPT_ADDR_RLD0L + 16'(2 * t), v[3:0]);
      wr_n(DPT_ADDR_RLD0H + 16'(2 * t), v[7:4]);
   endtask

   task automatic cnt(input int t, input logic [7:0] e, input string n);
      logic [3:0] lo;
      logic [3:0] hi;
      rd_n(DPT_ADDR_CNT0L + 16'(2 * t), lo);
      rd_n(DPT_ADDR_CNT0H + 16'(2 * t), hi);
      `CHK(n, e, {hi, lo})
   endtask

   // Edges on either source keep well clear of the input synchronisers
   task automatic edges(input logic f, input int n);
      repeat (n) begin
         @(posedge clk);
         if (f)
            fast <= 1'b1;
         else
            slow <= 1'b1;
         repeat (3) @(posedge clk);
         fast <= 1'b0;
         slow <= 1'b0;
         repeat (3) @(posedge clk);
      end
      repeat (8) @(posedge clk);
   endtask

   task automatic ev(input logic v, input int hold);
      @(posedge clk);
      evt <= v;
      repeat (hold) @(posedge clk);
   endtask

   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic close_out();
      $display("fail_count=%0d checks=%0d", fail_count, checks);
      if (fail_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (k = 0; k < 12; k++)
         rchk(16'hffc0 + 16'(k), 4'h0, "reset");
      rchk(DPT_ADDR_MASK, 4'h0, "mask reset");
      rchk(DPT_ADDR_FLAG, 4'h0, "flag reset");
      rchk(16'hffd0, 4'h0, "unmapped");
      wr_n(DPT_ADDR_MODE, 4'hf);
      rchk(DPT_ADDR_MODE, 4'h7, "mode bit3");
      wr_n(DPT_ADDR_MODE, 4'h0);
      wr_n(DPT_ADDR_PSR1, 4'he);
      rchk(DPT_ADDR_PSR1, 4'hc, "psr1 wo");
      wr_n(DPT_ADDR_PSR1, 4'h0);
      for (k = 4; k < 8; k++) begin
         seed = xs(seed);
         wr_n(16'hffc0 + 16'(k), seed[3:0]);
         rchk(16'hffc0 + 16'(k), seed[3:0], "reload rw");
      end
      wr_n(DPT_ADDR_CNT0L, 4'ha);
      rchk(DPT_ADDR_CNT0L, 4'h0, "count ro");
      wr_n(DPT_ADDR_MASK, 4'hf);
      rchk(DPT_ADDR_MASK, 4'h3, "mask rw");
      seed = xs(seed);
      wr_n(DPT_ADDR_OUTCK, seed[3:0]);
      rchk(DPT_ADDR_OUTCK, seed[3:0], "outck rw");
      // Timer 0 on the fast source, timer 1 on the slow one
      wr_n(DPT_ADDR_OUTCK, 4'h1);
      for (int c = 0; c < 4; c++) begin
         seed = xs(seed);
         r0 = {1'b1, seed[6:0]};
         r1 = {1'b1, seed[14:8]};
         ld(0, r0);
         ld(1, r1);
         wr_n(DPT_ADDR_PSR0, {c[1:0], 2'b10});
         wr_n(DPT_ADDR_PSR1, {c[1:0], 2'b10});
         cnt(0, r0, "reload0");
         cnt(1, r1, "reload1");
         wr_n(DPT_ADDR_PSR0, {c[1:0], 2'b01});
         wr_n(DPT_ADDR_PSR1, {c[1:0], 2'b01});
         edges(1'b1, 2 * dv(c));
         cnt(1, r1, "t1 on fast");
         wr_n(DPT_ADDR_PSR0, {c[1:0], 2'b00});
         cnt(0, r0 - 8'd2, "t0 ratio");
         edges(1'b0, 2 * dv(c));
         // Feed timer 0's own source while it is halted
         edges(1'b1, 4);
         cnt(0, r0 - 8'd2, "t0 stopped");
         cnt(1, r1 - 8'd2, "t1 ratio");
         wr_n(DPT_ADDR_PSR1, 4'h0);
      end
      // Underflow, flag, mask and square output
      ld(0, 8'h01);
      wr_n(DPT_ADDR_MASK, 4'h3);
      wr_n(DPT_ADDR_OUTCK, 4'h5);
      wr_n(DPT_ADDR_PSR0, 4'h3);
      rchk(DPT_ADDR_PSR0, 4'h1, "run rd");
      edges(1'b1, 2);
      for (k = 0; k < 20 && irq0 !== 1'b1; k++)
         @(posedge clk);
      `CHK("irq0", 1'b1, irq0)
      if (irq0 !== 1'b1)
         close_out();
      wr_n(DPT_ADDR_PSR0, 4'h0);
      rchk(DPT_ADDR_FLAG, 4'h1, "flag set");
      `CHK("sq t0", 1'b1, sq)
      cnt(0, 8'h01, "reloaded");
      wr_n(DPT_ADDR_OUTCK, 4'hd);
      settle();
      `CHK("sq t1", 1'b0, sq)
      wr_n(DPT_ADDR_OUTCK, 4'h1);
      settle();
      `CHK("sq off", 1'b0, sq)
      wr_n(DPT_ADDR_MASK, 4'h2);
      settle();
      `CHK("irq0 masked", 1'b0, irq0)
      wr_n(DPT_ADDR_FLAG, 4'h0);
      rchk(DPT_ADDR_FLAG, 4'h1, "flag w0");
      wr_n(DPT_ADDR_FLAG, 4'h1);
      rchk(DPT_ADDR_FLAG, 4'h0, "flag w1");
      // Timer 1 underflow on the slow source
      ld(1, 8'h00);
      wr_n(DPT_ADDR_PSR1, 4'h3);
      edges(1'b0, 1);
      wr_n(DPT_ADDR_PSR1, 4'h0);
      `CHK("irq1", 1'b1, irq1)
      wr_n(DPT_ADDR_OUTCK, 4'hd);
      settle();
      `CHK("sq t1 on", 1'b1, sq)
      wr_n(DPT_ADDR_FLAG, 4'h2);
      rchk(DPT_ADDR_FLAG, 4'h0, "flag1 w1");
      `CHK("irq1 clear", 1'b0, irq1)
      wr_n(DPT_ADDR_OUTCK, 4'h1);
      // Event counting on timer 0
      ld(0, 8'h80);
      wr_n(DPT_ADDR_MODE, 4'h5);
      wr_n(DPT_ADDR_PSR0, 4'h3);
      ev(1'b1, 10);
      cnt(0, 8'h7f, "rise");
      wr_n(DPT_ADDR_MODE, 4'h4);
      ev(1'b0, 10);
      cnt(0, 8'h7e, "fall");
      ev(1'b1, 10);
      cnt(0, 8'h7e, "no rise");
      ev(1'b0, 2);
      ev(1'b1, 10);
      cnt(0, 8'h7d, "short no nr");
      wr_n(DPT_ADDR_MODE, 4'h6);
      ev(1'b0, 2);
      ev(1'b1, 10);
      cnt(0, 8'h7d, "glitch nr");
      ev(1'b0, 10);
      cnt(0, 8'h7c, "long nr");
      wr_n(DPT_ADDR_MODE, 4'h0);
      ev(1'b1, 10);
      ev(1'b0, 10);
      cnt(0, 8'h7c, "timer mode");
      close_out();
   end

endmodule // dual_programmable_timer_tb
`default_nettype wire
